// >>> rscr_top.sv
// Purpose: reset state forcing and config-bit reload
// Assumes: sys_rst is the power-on reset, other sources are pins
// Notes: one clock, clkEn freezes every flip-flop
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "rscr_consts.svh"
module rscr_top (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // reset sources from outside the clock domain
    input wire logic rstPin,
    input wire logic wdtTimeout,
    input wire logic brownout,
    // non-volatile config bytes
    input wire rscr_pkg::rscr_cfg_s cfgBytes,
    // register port
    input wire rscr_pkg::rscr_bus_s busReq,
    output logic [7:0] busRdata,
    // core-facing reset state
    output logic cpuHold,
    output rscr_pkg::rscr_arch_s archInit,
    output logic ramWriteBlock,
    output logic ramUndefined,
    // loaded settings
    output logic bootFromLoader,
    output logic fetchExternal,
    output logic brownoutDetectEn,
    output logic brownoutResetEn
);
    import rscr_pkg::*;

    // two-flop synchronisers for pin sources
    logic [2:0] syncA_reg;
    logic [2:0] syncB_reg;
    // sequencer
    rscr_state_e state_reg;
    logic [1:0] loadCnt_reg;
    // true while only a software reset caused the hold
    logic swOnly_reg;
    // software reset request, one cycle
    logic swReq_reg;
    // loaded control bits
    logic boot_source_bit_reg;
    logic brownout_detect_enable_reg;
    logic brownout_reset_enable_reg;
    logic [7:0] code_flash_boundary_reg;
    // reset-cause flags
    logic flagSw_reg;
    logic flagBor_reg;
    logic flagWdt_reg;
    logic flagPor_reg;
    // architectural init values
    rscr_arch_s arch_reg;
    logic [7:0] rdata_reg;
    // boundary decode kept in a flip-flop beside the boundary it mirrors
    logic fetchExt_reg;
    // register views assembled from the field positions
    logic [7:0] ctrlView;
    logic [7:0] flagView;
    logic [7:0] infoView;

    // synchronised sources
    logic pinSync;
    logic wdtSync;
    logic borSync;
    logic borTrip;
    logic hwSrc;
    logic anySrc;
    logic wrCtrl;
    logic wrFlags;

    assign pinSync = syncB_reg[0];
    assign wdtSync = syncB_reg[1];
    assign borSync = syncB_reg[2];
    // brown-out resets only while the reset enable is on
    assign borTrip = borSync & brownout_reset_enable_reg;
    assign hwSrc = pinSync | wdtSync | borTrip;
    assign anySrc = hwSrc | swReq_reg;

    // address decode, shared by write paths
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    assign wrCtrl = busReq.wr & hit(busReq.addr, `RSCR_OFF_CTRL);
    assign wrFlags = busReq.wr & hit(busReq.addr, `RSCR_OFF_FLAGS);

    // synchroniser chain, first stage read only by second
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            syncA_reg <= 3'h0;
            syncB_reg <= 3'h0;
        end else if (clkEn) begin
            syncA_reg <= {brownout, wdtTimeout, rstPin};
            syncB_reg <= syncA_reg;
        end
    end

    // software reset strobe from the control register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            swReq_reg <= 1'b0;
        end else if (clkEn) begin
            // only taken while running, so a pending hold is not extended
            swReq_reg <= wrCtrl & busReq.wdata[`RSCR_CTRL_SWRST] & (state_reg == ST_RUN);
        end
    end

    // reset sequencer: hold while any source, then copy, then run
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            // power-on enters hold so the copy follows release
            state_reg <= ST_HOLD;
            loadCnt_reg <= 2'd0;
        end else if (clkEn) begin
            case (state_reg)
                ST_HOLD: begin
                    // stay held as long as a source remains
                    if (!anySrc) begin
                        state_reg <= ST_LOAD; // R3
                        loadCnt_reg <= 2'd0;
                    end
                end
                ST_LOAD: begin
                    if (anySrc) begin
                        // a new source restarts the hold
                        state_reg <= ST_HOLD;
                    end else if (loadCnt_reg == `RSCR_LOAD_CYCLES - 2'd1) begin
                        // copy done before the counter is released
                        state_reg <= ST_RUN; // R17
                    end else begin
                        loadCnt_reg <= loadCnt_reg + 2'd1;
                    end
                end
                ST_RUN: begin
                    if (anySrc) begin
                        state_reg <= ST_HOLD;
                    end
                end
                default: begin
                    state_reg <= ST_HOLD;
                end
            endcase
        end
    end

    // track whether the current hold came only from software
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            // power-on is not a software reset
            swOnly_reg <= 1'b0;
        end else if (clkEn) begin
            if (hwSrc) begin
                swOnly_reg <= 1'b0;
            end else if (swReq_reg) begin
                swOnly_reg <= 1'b1;
            end else if (state_reg == ST_RUN) begin
                swOnly_reg <= 1'b0;
            end
        end
    end

    // config-derived control bits; software owns them while running
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            // erased config values until the first copy
            boot_source_bit_reg <= 1'b0;
            brownout_detect_enable_reg <= 1'b1;
            brownout_reset_enable_reg <= 1'b1;
            code_flash_boundary_reg <= `RSCR_CFG_ERASED; // R8
        end else if (clkEn) begin
            if (state_reg == ST_LOAD) begin
                // boot bit is kept across a software-only reset
                if (!swOnly_reg) begin
                    boot_source_bit_reg <= ~cfgBytes.byte0[`RSCR_CFG0_BOOTSEL]; // R14 R10
                end
                brownout_detect_enable_reg <= cfgBytes.byte2[`RSCR_CFG2_BOD]; // R16 R9
                brownout_reset_enable_reg <= cfgBytes.byte2[`RSCR_CFG2_BOR]; // R16 R9
                code_flash_boundary_reg <= cfgBytes.byte1; // R9
            end else if (state_reg == ST_RUN && wrCtrl) begin
                // free software access after the copy
                boot_source_bit_reg <= busReq.wdata[`RSCR_CTRL_BOOT]; // R11
                brownout_detect_enable_reg <= busReq.wdata[`RSCR_CTRL_BOD]; // R11
                brownout_reset_enable_reg <= busReq.wdata[`RSCR_CTRL_BOR]; // R11
            end
        end
    end

    // reset-cause flags: power-on clears all but the power-on flag, which it sets; a write of one clears them, set beats clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flagSw_reg <= 1'b0;
            flagBor_reg <= 1'b0;
            flagWdt_reg <= 1'b0;
            flagPor_reg <= 1'b1; // R2
        end else if (clkEn) begin
            // write one clears, but a same-cycle event still sets
            if (swReq_reg) begin
                flagSw_reg <= 1'b1; // R7
            end else if (wrFlags && busReq.wdata[`RSCR_FLAG_SW]) begin
                flagSw_reg <= 1'b0;
            end
            if (borTrip) begin
                flagBor_reg <= 1'b1; // R7
            end else if (wrFlags && busReq.wdata[`RSCR_FLAG_BOR]) begin
                flagBor_reg <= 1'b0;
            end
            if (wdtSync) begin
                flagWdt_reg <= 1'b1; // R7
            end else if (wrFlags && busReq.wdata[`RSCR_FLAG_WDT]) begin
                flagWdt_reg <= 1'b0;
            end
            if (wrFlags && busReq.wdata[`RSCR_FLAG_POR]) begin
                flagPor_reg <= 1'b0;
            end
        end
    end

    // fetch decision registered so the fetch unit never sees a decode glitch
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            // erased boundary is not zero, so internal fetch until the copy
            fetchExt_reg <= 1'b0;
        end else if (clkEn) begin
            if (state_reg == ST_LOAD) begin
                // loaded in the same cycles as the boundary byte itself
                fetchExt_reg <= (cfgBytes.byte1 == `RSCR_BOUND_NONE); // R13
            end
        end
    end

    // architectural init values presented to the core
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            arch_reg.pc <= `RSCR_PC_RESET;
            arch_reg.sp <= `RSCR_SP_RESET;
            arch_reg.portLatch <= {4{`RSCR_PORT_RESET}};
            arch_reg.intEnable <= 1'b0;
            arch_reg.timerEnable <= 1'b0;
        end else if (clkEn) begin
            // constants every cycle, the core loads them while held
            arch_reg.pc <= `RSCR_PC_RESET; // R3
            arch_reg.sp <= `RSCR_SP_RESET; // R4
            arch_reg.portLatch <= {4{`RSCR_PORT_RESET}}; // R6
            arch_reg.intEnable <= 1'b0; // R5
            arch_reg.timerEnable <= 1'b0; // R5
        end
    end

    // read views; positions come from the field constants, the rest reads zero
    always_comb begin
        ctrlView = 8'h00;
        flagView = 8'h00;
        infoView = 8'h00;
        // control bits as software left them or as the copy loaded them
        ctrlView[`RSCR_CTRL_BOOT] = boot_source_bit_reg;
        ctrlView[`RSCR_CTRL_BOD] = brownout_detect_enable_reg;
        ctrlView[`RSCR_CTRL_BOR] = brownout_reset_enable_reg;
        // reset causes; the pin source has no flag of its own
        flagView[`RSCR_FLAG_SW] = flagSw_reg;
        flagView[`RSCR_FLAG_BOR] = flagBor_reg;
        flagView[`RSCR_FLAG_WDT] = flagWdt_reg;
        flagView[`RSCR_FLAG_POR] = flagPor_reg;
        // status lets software see where the next boot will fetch from
        infoView[`RSCR_INFO_EXT] = fetchExternal;
        infoView[`RSCR_INFO_BOOT] = bootFromLoader;
        infoView[`RSCR_INFO_HOLD] = cpuHold;
    end

    // read data, one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else if (clkEn) begin
            if (busReq.rd) begin
                case (busReq.addr)
                    `RSCR_OFF_CTRL: begin
                        // reset strobe reads as zero
                        rdata_reg <= ctrlView;
                    end
                    `RSCR_OFF_FLAGS: begin
                        rdata_reg <= flagView;
                    end
                    `RSCR_OFF_INFO: begin
                        rdata_reg <= infoView;
                    end
                    `RSCR_OFF_BOUND: begin
                        rdata_reg <= code_flash_boundary_reg;
                    end
                    default: begin
                        // unmapped reads zero
                        rdata_reg <= 8'h00;
                    end
                endcase
            end else begin
                rdata_reg <= 8'h00;
            end
        end
    end

    // core held in hold and copy states
    assign cpuHold = (state_reg != ST_RUN); // R3 R17
    // no RAM writes while held; RAM itself is never cleared
    assign ramWriteBlock = cpuHold; // R1
    // power-on flag doubles as the RAM-undefined marker
    assign ramUndefined = flagPor_reg; // R2
    assign archInit = arch_reg;
    assign busRdata = rdata_reg;
    // boot source seen by the fetch unit after release
    assign bootFromLoader = boot_source_bit_reg; // R15
    // zero boundary means no internal application area
    assign fetchExternal = fetchExt_reg; // R13
    assign brownoutDetectEn = brownout_detect_enable_reg;
    assign brownoutResetEn = brownout_reset_enable_reg;
endmodule
`default_nettype wire

// >>> rscr_consts.svh
// Functional notes
// R1 - RAM untouched while reset is applied
// R2 - RAM contents undefined after power-on
// R3 - program counter forced zero during reset
// R4 - stack pointer loads 07h every reset
// R5 - interrupts and timers disabled after reset
// R6 - port latches written all ones
// R7 - registers reset except reset-cause flags
// R8 - four config bytes, erased value ones
// R9 - copy config bits after each reset
// R10 - software reset keeps boot-source bit
// R11 - software may change loaded bits later
// R12 - unused config bits stay unprogrammed
// R13 - zero boundary means external fetch only
// R14 - boot bit from inverted boot-select
// R15 - boot bit zero selects application area
// R16 - brown-out enables from third byte bits
// R17 - finish copy before releasing program counter
//
// Purpose: offsets, field positions, reset values and counts
// Assumes: included by the reset-state block
// Notes: register map sits on a small plain port
`ifndef RSCR_CONSTS_SVH
`define RSCR_CONSTS_SVH
// register offsets
`define RSCR_OFF_CTRL 4'h0
`define RSCR_OFF_FLAGS 4'h1
`define RSCR_OFF_INFO 4'h2
`define RSCR_OFF_BOUND 4'h3
// control register fields
`define RSCR_CTRL_BOOT 0
`define RSCR_CTRL_BOD 1
`define RSCR_CTRL_BOR 2
`define RSCR_CTRL_SWRST 7
// flag register fields
`define RSCR_FLAG_SW 0
`define RSCR_FLAG_BOR 2
`define RSCR_FLAG_WDT 3
`define RSCR_FLAG_POR 4
// status register fields
`define RSCR_INFO_EXT 0
`define RSCR_INFO_BOOT 1
`define RSCR_INFO_HOLD 2
// config byte fields
`define RSCR_CFG0_BOOTSEL 7
`define RSCR_CFG2_BOD 7
`define RSCR_CFG2_BOR 4
// reset values
`define RSCR_PC_RESET 16'h0000
`define RSCR_SP_RESET 8'h07
`define RSCR_PORT_RESET 8'hff
`define RSCR_CFG_ERASED 8'hff
`define RSCR_BOUND_NONE 8'h00
// cycles spent copying config bits
`define RSCR_LOAD_CYCLES 2'd2
`endif

// >>> rscr_pkg.sv
// Purpose: shared types of the reset-state block
// Assumes: constants come from rscr_consts.svh
// Notes: types only
`default_nettype none
package rscr_pkg;
    // sequencer states
    typedef enum logic [1:0] {ST_HOLD, ST_LOAD, ST_RUN} rscr_state_e;
    // four non-volatile config bytes
    typedef struct packed {
        logic [7:0] byte3;
        logic [7:0] byte2;
        logic [7:0] byte1;
        logic [7:0] byte0;
    } rscr_cfg_s;
    // architectural values the core takes on while held
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] sp;
        logic [31:0] portLatch;
        logic intEnable;
        logic timerEnable;
    } rscr_arch_s;
    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rscr_bus_s;
endpackage
`default_nettype wire

// >>> rscr_chk.sv
// Purpose: port checks of the reset-state block
// Assumes: config bytes change only under sys_rst
// Notes: bound to rscr_top below the module
`timescale 1ns/1ps
`default_nettype none
module rscr_chk (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // inputs seen
    input wire logic rstPin,
    input wire rscr_pkg::rscr_cfg_s cfgBytes,
    // outputs seen
    input wire logic cpuHold,
    input wire rscr_pkg::rscr_arch_s archInit,
    input wire logic ramWriteBlock,
    input wire logic fetchExternal,
    input wire logic brownoutDetectEn,
    input wire logic brownoutResetEn
);
    import rscr_pkg::*;
    // one clock domain, checks idle in power-on reset
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    pc_zero_a: assert property (cpuHold |-> archInit.pc == 16'h0000)
        else $error("pc not zero in hold");
    sp_init_a: assert property (cpuHold |-> archInit.sp == 8'h07)
        else $error("sp not 07 in hold");
    irq_off_a: assert property (cpuHold |-> !archInit.intEnable && !archInit.timerEnable)
        else $error("irq or timer on in hold");
    port_ones_a: assert property (cpuHold |-> &archInit.portLatch)
        else $error("port latch not all ones");
    ram_guard_a: assert property (ramWriteBlock == cpuHold)
        else $error("ram block differs from hold");
    // two sync flops plus the state register, one edge spare
    pin_hold_a: assert property ($rose(rstPin) |-> ##[1:4] cpuHold)
        else $error("pin reset not seen");
    ext_fetch_a: assert property (!cpuHold |->
        fetchExternal == (cfgBytes.byte1 == 8'h00))
        else $error("external fetch wrong");
    // the copy must be complete at the edge that frees the core
    load_done_a: assert property ($fell(cpuHold) |->
        brownoutDetectEn == cfgBytes.byte2[7] && brownoutResetEn == cfgBytes.byte2[4])
        else $error("brown-out bits not loaded at release");
endmodule
bind rscr_top rscr_chk u_rscr_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .rstPin(rstPin), .cfgBytes(cfgBytes),
    .cpuHold(cpuHold), .archInit(archInit), .ramWriteBlock(ramWriteBlock),
    .fetchExternal(fetchExternal), .brownoutDetectEn(brownoutDetectEn),
    .brownoutResetEn(brownoutResetEn)
);
`default_nettype wire

// >>> rscr_top_test.sv
// Purpose: directed bench for the reset-state block
// Assumes: clkEn held high except in t_freeze, config changes only under sys_rst
// Notes: reset flags accumulate across scenarios on purpose once t_sw has cleared them
`timescale 1ns/1ps
`default_nettype none
module rscr_top_test;
    import rscr_pkg::*;
    logic ref_clk, sys_rst, clkEn, rstPin, wdtTimeout, brownout;
    logic cpuHold, ramBlk, ramUndef, boot, ext, brownout_detect_enable, borEn;
    logic [7:0] busRdata;
    rscr_cfg_s cfgBytes;
    rscr_bus_s busReq;
    rscr_arch_s archInit;
    int error_cnt = 0;
    int total_checks = 0;
    rscr_top u_rscr_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .rstPin(rstPin), .wdtTimeout(wdtTimeout), .brownout(brownout),
        .cfgBytes(cfgBytes), .busReq(busReq), .busRdata(busRdata),
        .cpuHold(cpuHold), .archInit(archInit), .ramWriteBlock(ramBlk),
        .ramUndefined(ramUndef), .bootFromLoader(boot), .fetchExternal(ext),
        .brownoutDetectEn(brownout_detect_enable), .brownoutResetEn(borEn));
    // counted compare, case equality so unknowns fail
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        busReq <= {a, d, 2'b10};
        @(posedge ref_clk);
        busReq <= '0;
    endtask
    // read, data only stands in the following cycle
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        busReq <= {a, 8'h00, 2'b01};
        @(posedge ref_clk);
        busReq <= '0;
        #1 chk(busRdata, exp);
    endtask
    // bounded wait for the hold level, a hang ends the run
    task automatic wait_hold(input logic lvl);
        int n;
        n = 0;
        while (cpuHold !== lvl && n < 20) begin
            @(posedge ref_clk);
            #1 n++;
        end
        if (cpuHold !== lvl) begin
            chk(cpuHold, lvl);
            wrap_up();
        end
    endtask
    // raise one source: 0 pin, 1 watchdog, 2 brown-out
    task automatic pulse_src(input int which, input int n);
        @(posedge ref_clk);
        {brownout, wdtTimeout, rstPin} <= 3'b001 << which;
        repeat (n) @(posedge ref_clk);
        {brownout, wdtTimeout, rstPin} <= 3'b000;
    endtask
    task automatic do_por(input rscr_cfg_s cfg);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        cfgBytes <= cfg;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1 chk(archInit.sp, 8'h07);
        chk(ramBlk, 1'b1);
        wait_hold(1'b0);
        chk(ramUndef, 1'b1);
    endtask
    // boot select and brown-out bits programmed, boundary zero
    task automatic t_por_prog();
        do_por(32'hff6f_007f);
        chk({boot, ext, brownout_detect_enable, borEn}, 4'b1100);
        rdc(4'h1, 8'h10);
        rdc(4'h3, 8'h00);
        rdc(4'h2, 8'h03);
        rdc(4'hf, 8'h00);
    endtask
    // software reset keeps the boot bit but reloads the rest
    task automatic t_sw();
        wr(4'h0, 8'h02);
        rdc(4'h0, 8'h02);
        wr(4'h0, 8'h82);
        wait_hold(1'b1);
        wait_hold(1'b0);
        chk({boot, brownout_detect_enable}, 2'b00);
        rdc(4'h1, 8'h11);
        wr(4'h1, 8'hff);
        #1 chk(ramUndef, 1'b0);
    endtask
    task automatic t_pin();
        pulse_src(0, 5);
        wait_hold(1'b1);
        chk(archInit.pc, 16'h0000);
        chk(archInit.portLatch, 32'hffff_ffff);
        chk({archInit.intEnable, archInit.timerEnable}, 2'b00);
        wait_hold(1'b0);
        chk(boot, 1'b1);
        rdc(4'h1, 8'h00);
    endtask
    task automatic t_wdt();
        pulse_src(1, 3);
        wait_hold(1'b1);
        wait_hold(1'b0);
        rdc(4'h1, 8'h08);
    endtask
    // refused while disabled, honoured once software enables it
    task automatic t_bor();
        pulse_src(2, 6);
        #1 chk(cpuHold, 1'b0);
        repeat (3) @(posedge ref_clk);
        wr(4'h0, 8'h04);
        #1 chk({boot, borEn}, 2'b01);
        pulse_src(2, 4);
        wait_hold(1'b1);
        wait_hold(1'b0);
        chk({boot, borEn}, 2'b10);
        rdc(4'h1, 8'h0c);
    endtask
    // with the enable low a reset request and a watchdog pulse leave no trace
    task automatic t_freeze();
        @(posedge ref_clk);
        clkEn <= 1'b0;
        wr(4'h0, 8'h86);
        pulse_src(1, 4);
        @(posedge ref_clk);
        clkEn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 chk(cpuHold, 1'b0);
        rdc(4'h0, 8'h01);
        rdc(4'h1, 8'h0c);
    endtask
    // erased image: application area, internal fetch, enables on
    task automatic t_erased();
        do_por(32'hffff_ffff);
        chk({boot, ext, brownout_detect_enable, borEn}, 4'b0011);
        rdc(4'h2, 8'h00);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        sys_rst = 1'b1;
        clkEn = 1'b1;
        {brownout, wdtTimeout, rstPin} = 3'b000;
        busReq = '0;
        cfgBytes = '1;
        t_por_prog();
        t_sw();
        t_pin();
        t_wdt();
        t_bor();
        t_freeze();
        t_erased();
        wrap_up();
    end
endmodule
`default_nettype wire
